// >>> hw/tcl_defines.svh
// Constants of the tuner calibration host: device map, fields, timing.
// Definitions only; included by the link and host modules.
`ifndef TCL_DEFINES_SVH
`define TCL_DEFINES_SVH
`define TCL_REG_INSEL 8'h00
`define TCL_REG_TFS 8'h01
`define TCL_REG_TFP 8'h02
`define TCL_REG_VCO 8'h03
`define TCL_REG_ROMA 8'h04
`define TCL_REG_OVLD 8'h05
`define TCL_REG_ROMD 8'h06
`define TCL_REG_STAT 8'h07
`define TCL_INSEL_VLO 2'h0
`define TCL_INSEL_VHI 2'h1
`define TCL_INSEL_UHF 2'h2
`define TCL_VHI_MHZ 10'h064
`define TCL_UHF_MHZ 10'h146
`define TCL_ROM_LAST 4'h8
`define TCL_OD_MSB 7
`define TCL_OD_LSB 5
`define TCL_IND_MSB 6
`define TCL_IND_LSB 4
`define TCL_IND_LOW 3'h0
`define TCL_IND_HIGH 3'h7
`define TCL_TFS_MAX 8'hFF
`define TCL_TFP_MAX 8'h3F
`define TCL_SB_MAX 5'h17
`define TCL_DEV_ADDR 7'h60
`define TCL_DEN 40'h00003E8000
`define TCL_T1_MUL 40'h000000FA00
`define TCL_K4_MUL 40'h0000001000
`define TCL_SCL_NS 2500
`define TCL_LINK_NS 30
`define TCL_QTR_CYC ((`TCL_SCL_NS / 4 + `TCL_LINK_NS - 1) / `TCL_LINK_NS)
`endif

// >>> hw/tcl_pkg.sv
// Types shared by the tuner calibration host and its serial link engine.
// Constants live in tcl_defines.svh.
package tcl_pkg;
    typedef struct packed {
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } tcl_cmd_t;
    typedef struct packed {
        logic [7:0] data;
        logic nack;
    } tcl_rsp_t;
    typedef struct packed {
        logic [9:0] mhz;
        logic [1:0] vco_post_divider;
        logic [4:0] sb;
    } tcl_tune_t;
    typedef enum logic [1:0] {
        TCL_SYM_START = 2'b00,
        TCL_SYM_BYTE = 2'b01,
        TCL_SYM_RBYTE = 2'b10,
        TCL_SYM_STOP = 2'b11
    } tcl_sym_t;
    typedef enum logic [3:0] {
        TCL_S_IDLE = 4'b0000,
        TCL_S_ROMA = 4'b0001,
        TCL_S_ROMD = 4'b0010,
        TCL_S_OVL = 4'b0011,
        TCL_S_INSEL = 4'b0100,
        TCL_S_TFS = 4'b0101,
        TCL_S_TFP = 4'b0110,
        TCL_S_VCO = 4'b0111,
        TCL_S_STAT = 4'b1000,
        TCL_S_EVAL = 4'b1001
    } tcl_st_t;
endpackage

// >>> hw/tcl_link.sv
// Two-wire bus master engine on the link clock; one register access each.
// Assumes a free-running link clock and a command held stable until done.
`timescale 1ns/10ps
`include "tcl_defines.svh"
module tcl_link
    import tcl_pkg::*;
#(
    parameter logic [7:0] QTR = 8'(`TCL_QTR_CYC)
)
(
    input wire logic link_clk_in,
    input wire logic arst_n_in,
    input wire tcl_cmd_t cmd_in,
    input wire logic req_tgl_in,
    output tcl_rsp_t rsp_out,
    output logic done_tgl_out,
    output logic scl_out,
    output logic scl_oe_out,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic sda_in
);
    logic [2:0] rq_ff, nxt_rq;
    logic [1:0] sd_ff, nxt_sd;
    logic busy_ff, nxt_busy, done_ff, nxt_done, nack_ff, nxt_nack;
    logic scl_ff, nxt_scl, sda_ff, nxt_sda;
    logic [2:0] step_ff, nxt_step;
    logic [3:0] bit_ff, nxt_bit;
    logic [1:0] q_ff, nxt_q;
    logic [7:0] cnt_ff, nxt_cnt, rx_ff, nxt_rx, byt;
    tcl_cmd_t cap_ff, nxt_cap;
    tcl_sym_t sym;
    logic tick, isbyte;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        sym = TCL_SYM_STOP;
        byt = 8'hFF;
        case (step_ff)
            3'h0: sym = TCL_SYM_START;
            3'h1:
            begin
                sym = TCL_SYM_BYTE;
                byt = {`TCL_DEV_ADDR, 1'b0};
            end
            3'h2:
            begin
                sym = TCL_SYM_BYTE;
                byt = cap_ff.addr;
            end
            3'h3:
            begin
                sym = cap_ff.rd ? TCL_SYM_START : TCL_SYM_BYTE;
                byt = cap_ff.data;
            end
            3'h4:
            begin
                sym = cap_ff.rd ? TCL_SYM_BYTE : TCL_SYM_STOP;
                byt = {`TCL_DEV_ADDR, 1'b1};
            end
            3'h5: sym = cap_ff.rd ? TCL_SYM_RBYTE : TCL_SYM_STOP;
            default: sym = TCL_SYM_STOP;
        endcase
        isbyte = sym == TCL_SYM_BYTE || sym == TCL_SYM_RBYTE;
        tick = busy_ff && cnt_ff == QTR - 8'h01;
        // Data uses the second synchroniser stage; the request edge compares the second and third stages
        nxt_rq = {rq_ff[1:0], req_tgl_in};
        nxt_sd = {sd_ff[0], sda_in};
        {nxt_busy, nxt_done, nxt_nack, nxt_cap} =
            {busy_ff, done_ff, nack_ff, cap_ff};
        {nxt_step, nxt_bit, nxt_q, nxt_rx} = {step_ff, bit_ff, q_ff, rx_ff};
        nxt_cnt = tick ? 8'h00 : cnt_ff + 8'h01;
        if (!busy_ff)
        begin
            nxt_cnt = 8'h00;
            if (rq_ff[2] != rq_ff[1])
            begin
                nxt_busy = 1'b1;
                nxt_cap = cmd_in;
                {nxt_step, nxt_bit, nxt_q, nxt_nack} = 10'h000;
            end
        end
        else if (tick)
        begin
            nxt_q = q_ff + 2'h1;
            // Sample at the end of the high phase, just before SCL falls
            if (q_ff == 2'h2 && isbyte)
            begin
                if (bit_ff == 4'h8)
                    nxt_nack = nack_ff | (sym == TCL_SYM_BYTE && sd_ff[1]);
                else if (sym == TCL_SYM_RBYTE)
                    nxt_rx = {rx_ff[6:0], sd_ff[1]};
            end
            if (q_ff == 2'h3)
            begin
                nxt_bit = (isbyte && bit_ff != 4'h8) ? bit_ff + 4'h1 : 4'h0;
                if (!(isbyte && bit_ff != 4'h8))
                begin
                    nxt_step = step_ff + 3'h1;
                    if (sym == TCL_SYM_STOP)
                    begin
                        nxt_busy = 1'b0;
                        nxt_done = ~done_ff;
                    end
                end
            end
        end
        nxt_scl = !busy_ff || (q_ff[0] ^ q_ff[1]) ||
            (sym == TCL_SYM_STOP && q_ff == 2'h3);
        case (sym)
            TCL_SYM_START: nxt_sda = !q_ff[1];
            TCL_SYM_STOP: nxt_sda = q_ff[1];
            TCL_SYM_BYTE: nxt_sda = bit_ff[3] | byt[3'(4'h7 - bit_ff)];
            default: nxt_sda = 1'b1;
        endcase
        if (!busy_ff)
            nxt_sda = 1'b1;
    end

    always_ff @(posedge link_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            {rq_ff, sd_ff, busy_ff, done_ff, nack_ff} <= 8'h00;
            {scl_ff, sda_ff} <= 2'h3;
            {step_ff, bit_ff, q_ff, cnt_ff, rx_ff} <= 25'h0000000;
            cap_ff <= '0;
        end
        else
        begin
            {rq_ff, sd_ff, busy_ff, done_ff, nack_ff} <=
                {nxt_rq, nxt_sd, nxt_busy, nxt_done, nxt_nack};
            {scl_ff, sda_ff} <= {nxt_scl, nxt_sda};
            {step_ff, bit_ff, q_ff, cnt_ff, rx_ff} <=
                {nxt_step, nxt_bit, nxt_q, nxt_cnt, nxt_rx};
            cap_ff <= nxt_cap;
        end
    end

    // Open-drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_out = !scl_ff;
    assign sda_oe_out = !sda_ff;
    assign done_tgl_out = done_ff;
    assign rsp_out = '{data: rx_ff, nack: nack_ff};
endmodule

// >>> hw/tcl_host.sv
// Tuner calibration host: ROM readout, overload load, filter codes, lock.
// Assumes a device on the two-wire bus; link logic on link_clk_in.
//
// What this block does
// - Input select 00 below 100MHz, 01 below 326MHz, 10 from 326MHz.
// - Read all eight coefficient bytes on an init request and keep them.
// - Write ROM location, then read the readback field for its entry.
// - Copy overload code from ROM into the overload register.
// - Rewrite both cap codes on every channel change.
// - Series code: tenfold interpolation minus 10 VHF or 20 UHF.
// - Parallel code: tenfold interpolation, minus 10 only for UHF.
// - Intercepts scaled by 64, VHF slopes 16, UHF slopes 64.
// - Frequency term is the channel frequency in gigahertz.
// - Program post-divider 4, 8, 16 or 32 per channel.
// - Indicator 000: unlocked at bottom, select lower sub-band.
// - Indicator 111: unlocked at top, select higher sub-band.
// - Step sub-bands and accept the first locked setting.
`timescale 1ns/10ps
`include "tcl_defines.svh"
module tcl_host
    import tcl_pkg::*;
#(
    parameter logic [7:0] QTR = 8'(`TCL_QTR_CYC)
)
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic link_clk_in,
    input wire logic init_req_in,
    input wire logic tune_req_in,
    input wire tcl_tune_t tune_in,
    output logic busy_out,
    output logic done_out,
    output logic error_out,
    output logic locked_out,
    output logic rom_ok_out,
    output logic [7:0] tfs_out,
    output logic [5:0] tfp_out,
    output logic [4:0] sb_out,
    output logic [2:0] ind_out,
    output logic scl_out,
    output logic scl_oe_out,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic sda_in
);
    // Filter order: VLO-S, VLO-P, VHI-S, VHI-P, UHF-S, UHF-P (tenths)
    localparam logic [7:0] K1 [0:5] =
        '{8'h0B, 8'h08, 8'h0D, 8'h08, 8'h0A, 8'h08};
    localparam logic [7:0] K2 [0:5] =
        '{8'h16, 8'h10, 8'h19, 8'h10, 8'h1E, 8'h10};
    localparam logic [7:0] K3 [0:5] =
        '{8'h28, 8'h50, 8'h28, 8'h10, 8'h14, 8'h14};
    localparam logic [7:0] K4 [0:5] =
        '{8'h78, 8'h8C, 8'h50, 8'h20, 8'h1E, 8'h19};
    localparam logic [15:0] SM [0:5] =
        '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0040, 16'h0040};
    localparam logic [7:0] OFF [0:5] =
        '{8'h0A, 8'h00, 8'h0A, 8'h00, 8'h14, 8'h0A};

    tcl_st_t st_ff, nxt_st;
    tcl_cmd_t cmd_ff, nxt_cmd, bus_cmd;
    tcl_tune_t tune_ff, nxt_tune;
    tcl_rsp_t rsp;
    logic [7:0] rom_ff [0:8];
    logic [7:0] nxt_rom [0:8];
    logic [3:0] idx_ff, nxt_idx;
    logic [4:0] sb_ff, nxt_sb;
    logic [2:0] ind_ff, nxt_ind, dt_ff, nxt_dt;
    logic [7:0] tfs_ff, nxt_tfs, last_ff, nxt_last, tfs_c, tfp_c;
    logic [5:0] tfp_ff, nxt_tfp, xs, ys, xp, yp;
    logic [1:0] caps_ff, nxt_caps, band;
    logic wait_ff, nxt_wait, tgl_ff, nxt_tgl, ok_ff, nxt_ok;
    logic lock_ff, nxt_lock, err_ff, nxt_err, done_ff, nxt_done;
    logic bus_st, issue, fin;
    logic [63:0] cv;
    logic [2:0] ks;

    logic link_done;

    tcl_link #(
        .QTR(QTR)
    ) u_link (
        .link_clk_in(link_clk_in),
        .arst_n_in(arst_n_in),
        .cmd_in(cmd_ff),
        .req_tgl_in(tgl_ff),
        .rsp_out(rsp),
        .done_tgl_out(link_done),
        .scl_out(scl_out),
        .scl_oe_out(scl_oe_out),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .sda_in(sda_in)
    );

    // scaled interpolation
    // Kept in integers over 64*64*1000 so no fraction is lost
    function automatic logic [7:0] cap_code(input logic [2:0] k,
        input logic [5:0] x, input logic [5:0] y, input logic [9:0] f,
        input logic [7:0] mx);
        logic [39:0] p;
        logic [39:0] m;
        logic [39:0] q;
        p = 40'(K1[k]) * 40'(x) * `TCL_T1_MUL + 40'(K2[k]) * `TCL_DEN
            + 40'(K3[k]) * 40'(y) * 40'(SM[k]) * 40'(f);
        m = 40'(K4[k]) * `TCL_K4_MUL * 40'(f) + 40'(OFF[k]) * `TCL_DEN;
        q = (p > m) ? (p - m) / `TCL_DEN : 40'h0000000000;
        cap_code = (q > 40'(mx)) ? mx : q[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // unpack coefficients, MSB first from location 1
    always_comb
    begin
        cv = {rom_ff[1], rom_ff[2], rom_ff[3], rom_ff[4],
            rom_ff[5], rom_ff[6], rom_ff[7], rom_ff[8]};
        band = (tune_ff.mhz < `TCL_VHI_MHZ) ? `TCL_INSEL_VLO :
            (tune_ff.mhz < `TCL_UHF_MHZ) ? `TCL_INSEL_VHI : `TCL_INSEL_UHF;
        case (band)
            `TCL_INSEL_VLO: {xs, ys, xp, yp} =
                {cv[63:58], 2'h0, cv[57:54], cv[53:48], 2'h0, cv[47:44]};
            `TCL_INSEL_VHI: {xs, ys, xp, yp} =
                {cv[43:38], 2'h0, cv[37:34], cv[33:28], 2'h0, cv[27:24]};
            default: {xs, ys, xp, yp} = cv[23:0];
        endcase
        ks = {band, 1'b0};
        tfs_c = cap_code(ks, xs, ys, tune_ff.mhz, `TCL_TFS_MAX);
        tfp_c = cap_code(ks + 3'h1, xp, yp, tune_ff.mhz, `TCL_TFP_MAX);
        bus_st = 1'b1;
        bus_cmd = '{rd: 1'b0, addr: `TCL_REG_INSEL, data: {6'h00, band}};
        case (st_ff)
            // address write, then a separate readback read
            TCL_S_ROMA: bus_cmd = '{1'b0, `TCL_REG_ROMA, {4'h0, idx_ff}};
            TCL_S_ROMD: bus_cmd = '{1'b1, `TCL_REG_ROMD, 8'h00};
            TCL_S_OVL: bus_cmd = '{1'b0, `TCL_REG_OVLD,
                {5'h00, rom_ff[0][`TCL_OD_MSB:`TCL_OD_LSB]}};
            TCL_S_INSEL: bus_cmd.data = {6'h00, band};
            TCL_S_TFS: bus_cmd = '{1'b0, `TCL_REG_TFS, tfs_c};
            TCL_S_TFP: bus_cmd = '{1'b0, `TCL_REG_TFP, tfp_c};
            TCL_S_VCO: bus_cmd = '{1'b0, `TCL_REG_VCO,
                {tune_ff.vco_post_divider, 1'b0, sb_ff}};
            TCL_S_STAT: bus_cmd = '{1'b1, `TCL_REG_STAT, 8'h00};
            default: bus_st = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_dt = {dt_ff[1:0], link_done};
        fin = wait_ff && (dt_ff[2] != dt_ff[1]);
        issue = bus_st && !wait_ff;
        {nxt_st, nxt_cmd, nxt_tune, nxt_idx, nxt_sb, nxt_ind} =
            {st_ff, cmd_ff, tune_ff, idx_ff, sb_ff, ind_ff};
        {nxt_tfs, nxt_tfp, nxt_last, nxt_caps} =
            {tfs_ff, tfp_ff, last_ff, caps_ff};
        {nxt_wait, nxt_tgl, nxt_ok, nxt_lock, nxt_err} =
            {wait_ff, tgl_ff, ok_ff, lock_ff, err_ff};
        nxt_done = 1'b0;
        nxt_rom = rom_ff;
        if (issue)
        begin
            nxt_cmd = bus_cmd;
            nxt_tgl = ~tgl_ff;
            nxt_wait = 1'b1;
            if (st_ff == TCL_S_TFS)
                nxt_tfs = tfs_c;
            if (st_ff == TCL_S_TFP)
                nxt_tfp = tfp_c[5:0];
        end
        if (fin)
        begin
            nxt_wait = 1'b0;
            nxt_last = cmd_ff.addr;
            nxt_st = tcl_st_t'(st_ff + 4'h1);
            case (st_ff)
                TCL_S_ROMD:
                begin
                    nxt_rom[idx_ff] = rsp.data;
                    nxt_idx = idx_ff + 4'h1;
                    if (idx_ff != `TCL_ROM_LAST)
                        nxt_st = TCL_S_ROMA;
                end
                TCL_S_OVL:
                begin
                    nxt_ok = 1'b1;
                    nxt_done = 1'b1;
                    nxt_idx = idx_ff;
                    nxt_st = TCL_S_IDLE;
                end
                TCL_S_TFS: nxt_caps[0] = 1'b1;
                TCL_S_TFP: nxt_caps[1] = 1'b1;
                TCL_S_STAT:
                    nxt_ind = rsp.data[`TCL_IND_MSB:`TCL_IND_LSB];
                default: nxt_st = tcl_st_t'(st_ff + 4'h1);
            endcase
            if (rsp.nack)
            begin
                nxt_err = 1'b1;
                nxt_done = 1'b1;
                nxt_st = TCL_S_IDLE;
            end
        end
        case (st_ff)
            TCL_S_IDLE:
            begin
                if (init_req_in)
                begin
                    {nxt_idx, nxt_ok, nxt_err, nxt_lock} = 7'h00;
                    nxt_st = TCL_S_ROMA;
                end
                else if (tune_req_in && ok_ff)
                begin
                    nxt_tune = tune_in;
                    nxt_sb = tune_in.sb;
                    {nxt_caps, nxt_err, nxt_lock} = 4'h0;
                    nxt_st = TCL_S_INSEL;
                end
            end
            TCL_S_EVAL:
            begin
                nxt_st = TCL_S_VCO;
                if (ind_ff == `TCL_IND_LOW)
                begin
                    nxt_sb = sb_ff - 5'h01;
                    nxt_err = sb_ff == 5'h00;
                end
                else if (ind_ff == `TCL_IND_HIGH)
                begin
                    nxt_sb = sb_ff + 5'h01;
                    nxt_err = sb_ff == `TCL_SB_MAX;
                end
                else
                    nxt_lock = 1'b1;
                if (nxt_lock || nxt_err)
                begin
                    nxt_sb = sb_ff;
                    nxt_done = 1'b1;
                    nxt_st = TCL_S_IDLE;
                end
            end
            default: nxt_st = nxt_st;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_ff <= TCL_S_IDLE;
            {cmd_ff, tune_ff, idx_ff, sb_ff, ind_ff, dt_ff} <= '0;
            {tfs_ff, tfp_ff, last_ff, caps_ff} <= '0;
            {wait_ff, tgl_ff, ok_ff, lock_ff, err_ff, done_ff} <= '0;
            for (int i = 0; i < 9; i++)
                rom_ff[i] <= 8'h00;
        end
        else
        begin
            st_ff <= nxt_st;
            {cmd_ff, tune_ff, idx_ff, sb_ff, ind_ff, dt_ff} <=
                {nxt_cmd, nxt_tune, nxt_idx, nxt_sb, nxt_ind, nxt_dt};
            {tfs_ff, tfp_ff, last_ff, caps_ff} <=
                {nxt_tfs, nxt_tfp, nxt_last, nxt_caps};
            {wait_ff, tgl_ff, ok_ff, lock_ff, err_ff, done_ff} <=
                {nxt_wait, nxt_tgl, nxt_ok, nxt_lock, nxt_err, nxt_done};
            rom_ff <= nxt_rom;
        end
    end

    assign busy_out = st_ff != TCL_S_IDLE;
    assign done_out = done_ff;
    assign error_out = err_ff;
    assign locked_out = lock_ff;
    assign rom_ok_out = ok_ff;
    assign {tfs_out, tfp_out, sb_out, ind_out} =
        {tfs_ff, tfp_ff, sb_ff, ind_ff};

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    insel_low_a: assert property (
        st_ff == TCL_S_INSEL && issue && tune_ff.mhz < `TCL_VHI_MHZ
        |=> cmd_ff.data[1:0] == `TCL_INSEL_VLO && cmd_ff.addr == 8'h00)
        else $error("low band not selected");
    rom_full_a: assert property (
        $rose(ok_ff) |-> idx_ff == 4'h9 && $past(last_ff) == `TCL_REG_ROMD)
        else $error("rom marked valid before all entries");
    rom_split_a: assert property (
        st_ff == TCL_S_ROMD && issue |-> last_ff == `TCL_REG_ROMA)
        else $error("readback without prior address write");
    ovl_code_a: assert property (
        st_ff == TCL_S_OVL && issue
        |=> cmd_ff.data[2:0] == rom_ff[0][7:5] ##1 wait_ff)
        else $error("overload code not from rom");
    both_caps_a: assert property (
        $rose(lock_ff) |-> caps_ff == 2'h3)
        else $error("lock without both cap writes");
    tfp_clamp_a: assert property (
        st_ff == TCL_S_TFP && issue |=> cmd_ff.data[7:6] == 2'h0)
        else $error("parallel code exceeds field");
    vco_post_divider_field_a: assert property (
        st_ff == TCL_S_VCO && issue
        |=> cmd_ff.data[7:6] == $past(tune_ff.vco_post_divider))
        else $error("post divider not programmed");
    step_down_a: assert property (
        st_ff == TCL_S_EVAL && ind_ff == 3'h0 && sb_ff != 5'h00
        |=> sb_ff == $past(sb_ff) - 5'h01 && st_ff == TCL_S_VCO)
        else $error("no step to lower sub-band");
    step_up_a: assert property (
        st_ff == TCL_S_EVAL && ind_ff == 3'h7 && sb_ff != 5'h17
        |=> sb_ff == $past(sb_ff) + 5'h01 ##1 st_ff == TCL_S_VCO)
        else $error("no step to higher sub-band");
    first_lock_a: assert property (
        st_ff == TCL_S_EVAL && ind_ff != 3'h0 && ind_ff != 3'h7
        |=> st_ff == TCL_S_IDLE && lock_ff && done_ff)
        else $error("locked setting not accepted");
endmodule

// >>> bench/tcl_dev_model.sv
// Behavioural tuner device on the two-wire bus: registers, ROM, status.
// Assumes the bench resolves the open-drain wires with pull-ups.
`timescale 1ns/10ps
module tcl_dev_model #(
    parameter logic [71:0] ROM = '0
)
(
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [4:0] lock_sb_in,
    output logic sda_drv_out
);
    logic [7:0] dev_reg [0:7];
    logic [7:0] sh, dout, ptr;
    logic rd, por;
    int bitn, phase;
    function automatic logic [7:0] rdval(input logic [7:0] a);
        logic [2:0] ind;
        logic [4:0] sb;
        sb = dev_reg[3][4:0];
        ind = lock_sb_in > sb ? 3'h7 : (lock_sb_in < sb ? 3'h0 : 3'h3);
        case (a)
            8'h06: rdval = ROM[71 - 8 * dev_reg[4][3:0] -: 8];
            8'h07: rdval = {por, ind, 4'h0};
            default: rdval = dev_reg[a[2:0]];
        endcase
    endfunction
    initial
    begin
        sda_drv_out = 0;
        {bitn, phase, rd, por, ptr, sh, dout} = '0;
        por = 1;
        foreach (dev_reg[i]) dev_reg[i] = 8'h00;
    end
    always @(negedge sda_in) if (scl_in === 1'b1) {bitn, phase} = '0;
    always @(posedge scl_in)
    begin
        sh = {sh[6:0], sda_in};
        bitn++;
    end
    // cap codes and sub-band held as written
    always @(negedge scl_in)
    begin
        sda_drv_out = 0;
        if (bitn == 8 && phase < 3)
        begin
            if (phase == 0) rd = sh[0];
            sda_drv_out = phase > 0 || sh[7:1] == 7'h60;
            if (phase == 1) ptr = sh;
            if (phase == 2) dev_reg[ptr[2:0]] = sh;
            phase = phase == 2 ? 2 : phase + 1;
        end
        else if (bitn == 8) phase = 4;
        if (bitn == 9)
        begin
            bitn = 0;
            if (rd && phase == 1)
            begin
                dout = rdval(ptr);
                if (ptr == 8'h07) por = 0;
                phase = 3;
            end
        end
        if (phase == 3 && bitn < 8) sda_drv_out = ~dout[7 - bitn];
    end
endmodule

// >>> bench/test_tcl_host.sv
// Bench for the tuner calibration host against the device model.
// Runs the link with short quarters so the whole run stays bounded.
`timescale 1ns/10ps
module test_tcl_host;
    import tcl_pkg::*;
    localparam logic [71:0] ROM = 72'hA05AC3963CE1872D4B;
    // Coefficients in tenths; integer maths avoids float edge rounding
    int ka [6] = '{11, 8, 13, 8, 10, 8};
    int kb [6] = '{22, 16, 25, 16, 30, 16};
    int kd [6] = '{40, 80, 40, 16, 20, 20};
    int ke [6] = '{120, 140, 80, 32, 30, 25};
    int ko [6] = '{10, 0, 10, 0, 20, 10};
    int mhz [4] = '{60, 200, 500, 800};
    int sbs [4] = '{4, 7, 16, 22};
    int lks [4] = '{5, 6, 16, 31};
    logic clk_in = 0, link_clk_in = 0, arst_n_in = 0;
    logic init_req_in = 0, tune_req_in = 0, drv;
    logic [4:0] lock_sb = 5'h00;
    tcl_tune_t tune_in = '0;
    logic busy_out, done_out, error_out, locked_out, rom_ok_out;
    logic [7:0] tfs_out;
    logic [5:0] tfp_out;
    logic [4:0] sb_out;
    logic [2:0] ind_out;
    logic scl_out, scl_oe_out, sda_out, sda_oe_out;
    wire logic scl = ~scl_oe_out;
    wire logic sda = ~(sda_oe_out | drv);
    int miscompares = 0, total_checks = 0;
    always #2.5 clk_in = ~clk_in;
    initial
    begin
        #1.3;
        forever #15 link_clk_in = ~link_clk_in;
    end
    tcl_host #(.QTR(8'h02)) i_tcl_host (.clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .link_clk_in(link_clk_in), .init_req_in(init_req_in),
        .tune_req_in(tune_req_in), .tune_in(tune_in), .busy_out(busy_out),
        .done_out(done_out), .error_out(error_out), .locked_out(locked_out),
        .rom_ok_out(rom_ok_out), .tfs_out(tfs_out), .tfp_out(tfp_out),
        .sb_out(sb_out), .ind_out(ind_out), .scl_out(scl_out),
        .scl_oe_out(scl_oe_out), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .sda_in(sda));
    tcl_dev_model #(.ROM(ROM)) i_tcl_dev_model (.scl_in(scl), .sda_in(sda),
        .lock_sb_in(lock_sb), .sda_drv_out(drv));
    function automatic logic [7:0] ecode(input int f, input int par);
        int b, j, p, c0, c1, v;
        b = f < 100 ? 0 : (f < 326 ? 1 : 2);
        j = 2 * b + par;
        p = 63 - 20 * b - (b == 2 ? 12 : 10) * par;
        c0 = ROM[p -: 6];
        c1 = b == 2 ? ROM[p - 6 -: 6] : ROM[p - 6 -: 4];
        // Tenfold value scaled by 64000 to stay in integers
        v = ka[j] * c0 * 1000 + kb[j] * 64000
            + (kd[j] * c1 * (b == 2 ? 1 : 4) - ke[j] * 64) * f;
        v = v / 64000 - ko[j];
        if (v < 0) v = 0;
        if (v > (par ? 63 : 255)) v = par ? 63 : 255;
        return 8'(v);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Done is a one-cycle pulse, so sample it on every falling edge
    task automatic request(input logic init, input tcl_tune_t t);
        int n;
        tune_in = t;
        init_req_in = init;
        tune_req_in = !init;
        @(negedge clk_in);
        {init_req_in, tune_req_in} = 2'b00;
        for (n = 0; n < 40000 && done_out !== 1'b1; n++) @(negedge clk_in);
        if (n >= 40000)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask
    initial
    begin
        repeat (12) @(negedge clk_in);
        arst_n_in = 1;
        @(negedge clk_in);
        tune_req_in = 1;
        @(negedge clk_in);
        tune_req_in = 0;
        @(negedge clk_in);
        chk(8'({busy_out, rom_ok_out, done_out}), 8'h00);
        chk(8'({scl_out, sda_out}), 8'h00);
        request(1, '0);
        chk(8'(rom_ok_out), 8'h01);
        chk(i_tcl_dev_model.dev_reg[4], 8'h08);
        chk(i_tcl_dev_model.dev_reg[5], 8'(ROM[71:69]));
        for (int i = 0; i < 4; i++)
        begin
            lock_sb = 5'(lks[i]);
            @(negedge clk_in);
            request(0, {10'(mhz[i]), 2'(i), 5'(sbs[i])});
            chk(i_tcl_dev_model.dev_reg[0], 8'(i < 3 ? i : 2));
            chk(i_tcl_dev_model.dev_reg[1], ecode(mhz[i], 0));
            chk(tfs_out, ecode(mhz[i], 0));
            chk(i_tcl_dev_model.dev_reg[2], ecode(mhz[i], 1));
            chk(8'(tfp_out), ecode(mhz[i], 1));
            chk(8'(i_tcl_dev_model.dev_reg[3][7:6]), 8'(i));
            chk(8'({locked_out, error_out}), i < 3 ? 8'h02 : 8'h01);
            chk(8'(sb_out), 8'(i < 3 ? lks[i] : 23));
            chk(8'(ind_out), i < 3 ? 8'h03 : 8'h07);
        end
        report_and_stop();
    end
endmodule
